// [tdc_asserts.sv]
// Port checker for the dual capture timer.
// Assumes a bind into every tdc_timer instance.
`timescale 1ns/1ps
`include "tdc_defines.svh"
module tdc_asserts (
  // Clock, reset, bus and interrupt
  input wire logic mclk,
  input wire logic sys_rst,
  input wire tdc_pkg::tdc_avreq_t av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire logic irq
);
  import tdc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc, rdn, wrn;
  logic [31:0] a, w;
  logic [2:0] en_r;
  assign acc = av_req.read | av_req.write;
  assign rdn = av_req.read & ~av_waitrequest;
  assign wrn = av_req.write & ~av_waitrequest;
  assign a = av_req.address;
  assign w = av_req.writedata;
  // Shadow of the three interrupt enables.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 3'h0;
    end else if (wrn && a == `TDC_OFS_CTRL) begin
      en_r[0] <= w[13];
    end else if (wrn && a == `TDC_OFS_CAPCFG) begin
      en_r[2:1] <= {w[20], w[6]};
    end
  end
  property p_wait; acc && av_waitrequest |=> !av_waitrequest; endproperty
  property p_first; $rose(acc) |-> av_waitrequest; endproperty
  property p_idle; !acc |-> !av_waitrequest; endproperty
  property p_ctrl; rdn && a == `TDC_OFS_CTRL |-> av_readdata[31:17] == 15'h0; endproperty
  property p_stat; rdn && a == `TDC_OFS_STATUS |-> av_readdata[31:16] == 16'h0; endproperty
  property p_res;
    rdn && (a == `TDC_OFS_RES1 || a == `TDC_OFS_RES2) |-> av_readdata[31:22] == 10'h0;
  endproperty
  property p_clr; rdn && a == `TDC_OFS_CLEAR |-> av_readdata == 32'h0; endproperty
  property p_mask; en_r == 3'h0 ##1 en_r == 3'h0 |-> !irq; endproperty
  a_wait: assert property (p_wait) else $error("wait longer than one cycle");
  a_first: assert property (p_first) else $error("no wait in first cycle");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_ctrl: assert property (p_ctrl) else $error("control upper bits set");
  a_stat: assert property (p_stat) else $error("status upper bits set");
  a_res: assert property (p_res) else $error("result upper bits set");
  a_clr: assert property (p_clr) else $error("clear reads nonzero");
  a_mask: assert property (p_mask) else $error("irq while masked");
  c_stat: cover property (rdn && a == `TDC_OFS_STATUS);
  c_irq: cover property ($rose(irq));
  c_clr: cover property (wrn && a == `TDC_OFS_CLEAR);
endmodule
bind tdc_timer tdc_asserts chk (.mclk(mclk), .sys_rst(sys_rst), .av_req(av_req),
  .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .irq(irq));

// [tdc_defines.svh]
// Register offsets, field positions and timing constants of the dual capture timer.
// Assumes inclusion by bare name from the checker, the design module and the bench.
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH
`define TDC_OFS_CTRL 32'h5000_4000
`define TDC_OFS_CAPCFG 32'h5000_4004
`define TDC_OFS_STATUS 32'h5000_4008
`define TDC_OFS_RES1 32'h5000_400c
`define TDC_OFS_RES2 32'h5000_4010
`define TDC_OFS_CLEAR 32'h5000_4014
`define TDC_CTRL_GATE 16
`define TDC_CTRL_FAST 15
`define TDC_CTRL_WRAPMAX 14
`define TDC_CTRL_TUNMASK 13
`define TDC_CTRL_DOWN 12
`define TDC_CTRL_RUN 11
`define TDC_CTRL_WMASK 32'h0001_ffff
`define TDC_CAP_WMASK 32'h0fff_ffff
`define TDC_CH_LSB1 0
`define TDC_CH_LSB2 14
`define TDC_ST_OVF1 14
`define TDC_ST_PEND2 13
`define TDC_ST_PEND1 12
`define TDC_ST_TPEND 11
`define TDC_CLR_IN2 2
`define TDC_CLR_IN1 1
`define TDC_CLR_TMR 0
`define TDC_CNT_MAX 11'h7ff
`define TDC_CNT_ZERO 11'h000
`define TDC_PIN_FIRST 4'h1
`define TDC_PIN_LAST 4'hc
`define TDC_SYNC_CYCLES 3
`endif

// [tdc_pins.sv]
// Pulse source on the port zero pins.
// Assumes the bench raises run for each pin that should toggle.
`timescale 1ns/1ps
module tdc_pins #(
  parameter int HALF = 6
) (
  // Clock and pins
  input wire logic mclk,
  input wire logic [11:0] run,
  output logic [11:0] port_zero
);
  int cnt = 0;
  initial port_zero = 12'h000;
  always @(posedge mclk) begin
    cnt <= (cnt + 1) % HALF;
    if (cnt == 0) begin
      port_zero <= port_zero ^ run;
    end
  end
endmodule

// [tdc_pkg.sv]
// Types shared by the dual capture timer.
// Assumes tdc_defines.svh is on the include path.
package tdc_pkg;
  // Per-channel configuration as laid out in the capture register.
  typedef struct packed {
    logic stamp_rtc;
    logic [5:0] period_count;
    logic irq_en;
    logic count_mode;
    logic falling;
    logic [3:0] pin_sel;
  } tdc_chcfg_t;
  // Avalon-MM request bundle.
  typedef struct packed {
    logic [31:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } tdc_avreq_t;
endpackage

// [tdc_timer.sv]
// Eleven bit timer with two edge-triggered capture or period-count inputs.
// Assumes an Avalon-MM master on mclk, port pins and an RTC stamp from other domains.
//
// Summary of operation
// - Bit 16 gates timer counting clock.
// - Bit 15 picks system clock over low-power.
// - Up count wraps at reload or maximum.
// - Bit 13 unmasks the timer interrupt.
// - Bit 12 selects decrement instead of increment.
// - Bit 11 enables timer operation.
// - Reload field sets count, plus three-cycle sync.
// - Stamp bit picks counter or RTC stamp.
// - Count mode spans period field plus one.
// - Channel interrupt enable masks capture interrupt.
// - Mode bit picks capture or count mode.
// - Edge bit picks rising or falling events.
// - Pin codes 1..12 select port-zero pins.
// - Event while pending sets overflow, keeps value.
// - Pending flags stay set until cleared.
// - Status low bits show live counter.
// - Count result is timer clocks minus one.
// - Capture result holds value plus stamp high.
// - Clear bits drop flags, read zero.
`timescale 1ns/1ps
`include "tdc_defines.svh"
module tdc_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire tdc_pkg::tdc_avreq_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Counting clocks, as level inputs from other domains
  input wire logic lp_clk,
  input wire logic sys_tick,
  // Port zero pins and RTC stamp
  input wire logic [11:0] port_zero,
  input wire logic [21:0] rtc_stamp,
  // Interrupt
  output logic irq
);
  import tdc_pkg::*;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] capcfg_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic [10:0] cnt_r;
  logic tpend_r;
  wire [1:0] pend_r;
  wire [1:0] ovf_r;
  wire [21:0] res_r [2];
  wire access = av_req.read | av_req.write;
  // One wait cycle per access; the answer comes on the second edge.
  assign av_waitrequest = access & ~ack_r;
  wire wr_go = av_req.write & ack_r;
  wire rd_go = av_req.read & ~ack_r;
  wire [31:0] bemask = {{8{av_req.byteenable[3]}}, {8{av_req.byteenable[2]}},
                        {8{av_req.byteenable[1]}}, {8{av_req.byteenable[0]}}};
  wire sel_ctrl = av_req.address == `TDC_OFS_CTRL;
  wire sel_cap = av_req.address == `TDC_OFS_CAPCFG;
  wire sel_st = av_req.address == `TDC_OFS_STATUS;
  wire sel_r1 = av_req.address == `TDC_OFS_RES1;
  wire sel_r2 = av_req.address == `TDC_OFS_RES2;
  wire sel_clr = av_req.address == `TDC_OFS_CLEAR;
  wire [31:0] ctrl_nxt = (ctrl_r & ~bemask) | (av_req.writedata & bemask & `TDC_CTRL_WMASK);
  wire [31:0] cap_nxt = (capcfg_r & ~bemask) | (av_req.writedata & bemask & `TDC_CAP_WMASK);
  wire [31:0] clr_bits = (wr_go & sel_clr) ? (av_req.writedata & bemask) : 32'h0000_0000;
  wire clr_tmr = clr_bits[`TDC_CLR_TMR];
  wire [1:0] clr_in = {clr_bits[`TDC_CLR_IN2], clr_bits[`TDC_CLR_IN1]};
  wire [31:0] status_word = {16'h0000, ovf_r, pend_r, tpend_r, cnt_r};
  // The clear register and unmapped offsets read as zero.
  wire [31:0] rd_mux = sel_ctrl ? ctrl_r :
                       sel_cap ? capcfg_r :
                       sel_st ? status_word :
                       sel_r1 ? {10'h000, res_r[0]} :
                       sel_r2 ? {10'h000, res_r[1]} : 32'h0000_0000;
  assign av_readdata = rdata_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= access & ~ack_r;
      if (rd_go) begin
        rdata_r <= rd_mux;
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= 32'h0000_0000;
      capcfg_r <= 32'h0000_0000;
    end else if (wr_go) begin
      if (sel_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (sel_cap) begin
        capcfg_r <= cap_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [13:0] sync1_r;
  logic [13:0] sync2_r;
  logic [21:0] rtc1_r;
  logic [21:0] rtc2_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 14'h0000;
      sync2_r <= 14'h0000;
      rtc1_r <= 22'h00_0000;
      rtc2_r <= 22'h00_0000;
    end else begin
      sync1_r <= {sys_tick, lp_clk, port_zero};
      sync2_r <= sync1_r;
      rtc1_r <= rtc_stamp;
      rtc2_r <= rtc1_r;
    end
  end

  // ----------------------------------------------------------------
  // Timer clock and counter
  // ----------------------------------------------------------------
  logic clk_src_d_r;
  wire src_lvl = ctrl_r[`TDC_CTRL_FAST] ? sync2_r[13] : sync2_r[12];
  wire src_rise = src_lvl & ~clk_src_d_r;
  wire tick = src_rise & ctrl_r[`TDC_CTRL_GATE];
  wire run = ctrl_r[`TDC_CTRL_RUN];
  wire [10:0] reload = ctrl_r[10:0];
  wire [10:0] top = ctrl_r[`TDC_CTRL_WRAPMAX] ? `TDC_CNT_MAX : reload;
  wire down = ctrl_r[`TDC_CTRL_DOWN];
  wire at_end = down ? (cnt_r == `TDC_CNT_ZERO) : (cnt_r == top);
  wire [10:0] cnt_nxt = !run ? `TDC_CNT_ZERO :
                        !tick ? cnt_r :
                        down ? (at_end ? reload : cnt_r - 11'h001) :
                        (at_end ? `TDC_CNT_ZERO : cnt_r + 11'h001);
  // Three timer-clock pipeline ahead of the counter, advancing only on tick, gives the documented sync latency.
  logic [`TDC_SYNC_CYCLES-1:0] run_pipe_r;
  wire timer_evt = tick & run & run_pipe_r[`TDC_SYNC_CYCLES-1] & at_end;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_src_d_r <= 1'b0;
      cnt_r <= `TDC_CNT_ZERO;
      run_pipe_r <= '0;
      tpend_r <= 1'b0;
    end else begin
      clk_src_d_r <= src_lvl;
      if (!run) begin
        run_pipe_r <= '0;
      end else if (tick) begin
        run_pipe_r <= {run_pipe_r[`TDC_SYNC_CYCLES-2:0], 1'b1};
      end
      cnt_r <= run_pipe_r[`TDC_SYNC_CYCLES-1] ? cnt_nxt : (run ? cnt_r : `TDC_CNT_ZERO);
      tpend_r <= timer_evt | (tpend_r & ~clr_tmr);
    end
  end

  // ----------------------------------------------------------------
  // Input channels
  // ----------------------------------------------------------------
  // Software keeps the edge bit steady while a pin is selected.
  logic [1:0] chan_irq;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      localparam int LSB = (g == 0) ? `TDC_CH_LSB1 : `TDC_CH_LSB2;
      tdc_chcfg_t cfg;
      logic pin_d_r;
      logic [5:0] per_r;
      logic [10:0] meas_r;
      logic armed_r;
      logic pend_ch_r;
      logic ovf_ch_r;
      logic [21:0] res_ch_r;
      assign cfg = capcfg_r[LSB+13:LSB];
      assign pend_r[g] = pend_ch_r;
      assign ovf_r[g] = ovf_ch_r;
      assign res_r[g] = res_ch_r;
      wire pin_ok = cfg.pin_sel >= `TDC_PIN_FIRST && cfg.pin_sel <= `TDC_PIN_LAST;
      wire [3:0] pidx = cfg.pin_sel - `TDC_PIN_FIRST;
      wire pin_lvl = pin_ok & sync2_r[pidx];
      wire edge_evt = pin_ok & (cfg.falling ? (pin_d_r & ~pin_lvl)
                                           : (~pin_d_r & pin_lvl));
      wire per_done = armed_r & (per_r == cfg.period_count);
      wire evt = cfg.count_mode ? (edge_evt & per_done) : edge_evt;
      wire [21:0] cap_val = cfg.stamp_rtc ? rtc2_r
                                          : {rtc2_r[21:11], cnt_r};
      // The span counts every tick from its opening edge, so the stored value is ticks less one.
      wire [21:0] cnt_val = {11'h000, meas_r - 11'h001};
      wire span_open = !armed_r || per_done;
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_d_r <= 1'b0;
          per_r <= 6'h00;
          meas_r <= `TDC_CNT_ZERO;
          armed_r <= 1'b0;
          pend_ch_r <= 1'b0;
          ovf_ch_r <= 1'b0;
          res_ch_r <= 22'h00_0000;
        end else begin
          pin_d_r <= pin_lvl;
          if (!cfg.count_mode || !pin_ok) begin
            armed_r <= 1'b0;
            per_r <= 6'h00;
          end else if (edge_evt) begin
            armed_r <= 1'b1;
            per_r <= span_open ? 6'h00 : per_r + 6'h01;
            if (span_open) begin
              meas_r <= {10'h000, tick};
            end else if (tick) begin
              meas_r <= meas_r + 11'h001;
            end
          end else if (tick) begin
            meas_r <= meas_r + 11'h001;
          end
          // A new event while pending sets overflow and keeps the first value.
          if (evt && !pend_ch_r) begin
            res_ch_r <= cfg.count_mode ? cnt_val : cap_val;
          end
          pend_ch_r <= evt | (pend_ch_r & ~clr_in[g]);
          ovf_ch_r <= (evt & pend_ch_r) | (ovf_ch_r & ~clr_in[g]);
        end
      end
      assign chan_irq[g] = pend_ch_r & cfg.irq_en;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic irq_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (tpend_r & ctrl_r[`TDC_CTRL_TUNMASK]) | (|chan_irq);
    end
  end
  assign irq = irq_r;
endmodule

// [tdc_timer_test.sv]
// Self-checking bench for the dual capture timer.
// Assumes the design, tdc_pins and tdc_asserts are compiled first.
`timescale 1ns/1ps
`include "tdc_defines.svh"
module tdc_timer_test;
  import tdc_pkg::*;
  logic mclk, sys_rst, lp_clk, sys_tick, av_waitrequest, irq;
  tdc_avreq_t av_req;
  logic [31:0] av_readdata, q, p;
  logic [11:0] port_zero, run;
  logic [21:0] rtc_stamp;
  int n_mismatch = 0;
  int n_compared = 0;
  int k;
  tdc_timer dut (.mclk(mclk), .sys_rst(sys_rst), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .lp_clk(lp_clk), .sys_tick(sys_tick),
    .port_zero(port_zero), .rtc_stamp(rtc_stamp), .irq(irq));
  tdc_pins pins (.mclk(mclk), .run(run), .port_zero(port_zero));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    sys_tick <= ~sys_tick;
    lp_clk <= lp_clk ^ sys_tick;
  end
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    av_req <= '{address: ad, read: ~wr, write: wr, byteenable: 4'hf, writedata: d};
    do begin
      @(posedge mclk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 50);
    q = av_readdata;
    n_mismatch += int'(n == 50);
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] m, input string s,
      input logic [31:0] e);
    bus(1'b0, ad, '0);
    chk(s, q & m, e);
  endtask
  task automatic wirq();
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    n_mismatch += int'(k == 3000);
  endtask
  task automatic t_count();
    bus(1'b1, `TDC_OFS_CAPCFG, '0);
    bus(1'b1, `TDC_OFS_CLEAR, 32'h0000_0007);
    bus(1'b1, `TDC_OFS_CTRL, 32'h0001_0000);
    bus(1'b1, `TDC_OFS_CAPCFG, 32'h0000_00e3);
    run <= 12'h004;
    wirq();
    rd(`TDC_OFS_RES1, '1, "period count", 32'h0000_0005);
    run <= '0;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rd(32'h5000_4000 + 32'(i * 4), '1, "reset", '0);
    end
    bus(1'b1, `TDC_OFS_CTRL, 32'hfffe_ffff);
    rd(`TDC_OFS_CTRL, '1, "control", 32'h0000_ffff);
    bus(1'b1, `TDC_OFS_CAPCFG, 32'hf3fc_3ff0);
    rd(`TDC_OFS_CAPCFG, '1, "capture config", 32'h03fc_3ff0);
    bus(1'b1, `TDC_OFS_STATUS, '1);
    rd(`TDC_OFS_STATUS, '1, "status", '0);
    rd(`TDC_OFS_CLEAR, '1, "clear", '0);
    bus(1'b1, `TDC_OFS_CAPCFG, '0);
  endtask
  task automatic t_timer();
    bus(1'b1, `TDC_OFS_CTRL, 32'h0001_a940);
    wirq();
    chk("timer delay", 32'(k > 642 && k < 662), 32'h1);
    rd(`TDC_OFS_STATUS, 32'h0000_f800, "timer pending", 32'h0000_0800);
    bus(1'b1, `TDC_OFS_CLEAR, 32'h0000_0001);
    rd(`TDC_OFS_STATUS, 32'h0000_f800, "timer cleared", '0);
    chk("wrapped counter", 32'(q[10:0] < 11'h020), 32'h1);
    chk("irq", {31'h0, irq}, '0);
    bus(1'b1, `TDC_OFS_CTRL, 32'h0000_a940);
  endtask
  task automatic t_capture();
    rtc_stamp <= 22'h2a_5555;
    bus(1'b1, `TDC_OFS_CAPCFG, 32'h0000_0041);
    run <= 12'h001;
    wirq();
    repeat (40) @(posedge mclk);
    rd(`TDC_OFS_STATUS, 32'h0000_f800, "input one flags", 32'h0000_5000);
    rd(`TDC_OFS_RES1, 32'hffff_f800, "input one stamp", 32'h002a_5000);
    p = q;
    run <= '0;
    repeat (30) @(posedge mclk);
    rd(`TDC_OFS_RES1, '1, "first event kept", p);
    bus(1'b1, `TDC_OFS_CLEAR, 32'h0000_0002);
    rd(`TDC_OFS_STATUS, 32'h0000_f800, "input one cleared", '0);
    bus(1'b1, `TDC_OFS_CAPCFG, 32'h0804_0000);
    bus(1'b1, `TDC_OFS_CAPCFG, 32'h0814_8000);
    run <= 12'h002;
    wirq();
    rd(`TDC_OFS_RES2, '1, "input two stamp", 32'h002a_5555);
    run <= '0;
  endtask
  initial begin
    sys_rst = 1'b1;
    av_req = '0;
    lp_clk = 1'b0;
    sys_tick = 1'b0;
    run = '0;
    rtc_stamp = '0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_timer();
    t_capture();
    t_count();
    summarize();
  end
  initial begin
    repeat (8000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule
